/* File: hw/load_meas_regs.vh */
`ifndef LOAD_MEAS_REGS_VH
`define LOAD_MEAS_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_MEAS_SELECT   8'h00
`define ADDR_RESULT_LOW    8'h01
`define ADDR_RESULT_HIGH   8'h02
`define ADDR_INT_FLAGS     8'h03
`define ADDR_INT_MASK      8'h04
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SEL_BIT            0
`define FLAG_DONE_BIT      0
`define MASK_DONE_BIT      0
`define RST_SELECT         8'h00
`define RST_MASK           8'h00
`define RESULT_W           9
`define LSB_MA             20
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ             20000000
`define MEAS_MAX_US        50
`define MEAS_MAX_CYC       ((`MEAS_MAX_US * (`CLK_HZ / 1000000)))
`endif

/* File: hw/buck_load_current_measure.v */
`timescale 1ns/1ps
`include "load_meas_regs.vh"
// Notes on behaviour
// - Measurement is requested and read through the byte register port.
// - Select bit picks first or second step-down converter for measurement.
// - Any write to the selection register starts a fresh measurement.
// - Selected converter is forced to fixed-frequency PWM while measuring.
// - Measurement finishes within 50 us of the triggering write.
// - Completion sets a sticky done flag in the interrupt register.
// - Mask bit set keeps the done flag off the host interrupt line.
// - Nine-bit result: low eight bits in low register, MSB in high.
// - One result step equals 20 mA of load current.
module buck_load_current_measure #(
   parameter MEAS_CYC = `MEAS_MAX_CYC,
   parameter CONV_CYC = 64
) (
   input  wire        i_clk,
   input  wire        i_rstn,
   input  wire        i_wr,
   input  wire        i_rd,
   input  wire [7:0]  i_addr,
   input  wire [7:0]  i_wdata,
   output reg  [7:0]  o_rdata,
   input  wire [8:0]  i_adc_first,
   input  wire [8:0]  i_adc_second,
   output wire        o_force_pwm_first,
   output wire        o_force_pwm_second,
   output wire        o_busy,
   output wire        o_host_interrupt_line_n
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_MEAS = 1'b1;
   reg        state_q;
   reg [7:0]  select_q;
   reg [7:0]  mask_q;
   reg        done_flag_q;
   reg [8:0]  result_q;
   reg [15:0] cnt_q;
   reg        sel_meas_q;
   wire       wr_sel  = i_wr && (i_addr == `ADDR_MEAS_SELECT);
   wire       clr_flg = i_wr && (i_addr == `ADDR_INT_FLAGS) && i_wdata[`FLAG_DONE_BIT];
   // Conversion window is capped by the max time so the 50 us limit always holds
   localparam integer END_CNT = (CONV_CYC < MEAS_CYC) ? CONV_CYC : MEAS_CYC;
   // Compare at full integer width so no constant is cut to fit the counter
   wire [31:0] end_last = END_CNT - 1;
   wire       finish  = (state_q == ST_MEAS) && ({16'h0000, cnt_q} >= end_last);
   // ----------------------------------------
   // Measurement sequencer
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         state_q     <= ST_IDLE;
         select_q    <= `RST_SELECT;
         mask_q      <= `RST_MASK;
         done_flag_q <= 1'b0;
         result_q    <= 9'h000;
         cnt_q       <= 16'h0000;
         sel_meas_q  <= 1'b0;
      end else begin
         if (i_wr && (i_addr == `ADDR_INT_MASK))
            mask_q <= i_wdata;
         if (wr_sel) begin
            // Restart even mid-measurement; earlier run is abandoned
            select_q   <= i_wdata;
            sel_meas_q <= i_wdata[`SEL_BIT];
            state_q    <= ST_MEAS;
            cnt_q      <= 16'h0000;
         end else if (state_q == ST_MEAS) begin
            if (finish) begin
               state_q <= ST_IDLE;
               // Code is current / 20 mA, sampled from the sensed converter
               result_q <= sel_meas_q ? i_adc_second : i_adc_first;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
         // Set wins over a simultaneous clear
         if (finish && !wr_sel)
            done_flag_q <= 1'b1;
         else if (clr_flg)
            done_flag_q <= 1'b0;
      end
   end
   assign o_busy             = (state_q == ST_MEAS);
   assign o_force_pwm_first  = o_busy && !sel_meas_q;
   assign o_force_pwm_second = o_busy && sel_meas_q;
   assign o_host_interrupt_line_n = !(done_flag_q && !mask_q[`MASK_DONE_BIT]);
   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `ADDR_MEAS_SELECT: o_rdata <= select_q;
            `ADDR_RESULT_LOW:  o_rdata <= result_q[7:0];
            `ADDR_RESULT_HIGH: o_rdata <= {7'h00, result_q[8]};
            `ADDR_INT_FLAGS:   o_rdata <= {7'h00, done_flag_q};
            `ADDR_INT_MASK:    o_rdata <= mask_q;
            default:           o_rdata <= 8'h00;
         endcase
      end
   end
endmodule // buck_load_current_measure

/* File: tb/sense_front_end.sv */
`timescale 1ns/1ps
module sense_front_end #(
   parameter logic [8:0] FIRST  = 9'h1a5,
   parameter logic [8:0] SECOND = 9'h0f3
) (
   output logic [8:0] o_first,
   output logic [8:0] o_second
);
   // Fixed codes so each converter shows a distinct value
   assign o_first  = FIRST;
   assign o_second = SECOND;
endmodule // sense_front_end

/* File: tb/load_meas_props.sv */
`timescale 1ns/1ps
module load_meas_props (
   input wire logic       i_clk,
   input wire logic       i_rstn,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic       o_force_pwm_first,
   input wire logic       o_force_pwm_second,
   input wire logic       o_busy,
   input wire logic       o_host_interrupt_line_n
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   wire sel_wr = i_wr && i_addr == 8'h00;
   start_busy_a: assert property (sel_wr |=> o_busy) else $error("busy");
   pick_conv_a: assert property (sel_wr |=> o_force_pwm_second == $past(i_wdata[0])) else $error("pick");
   one_pwm_a: assert property (o_busy |-> o_force_pwm_first ^ o_force_pwm_second) else $error("pwm");
   idle_pwm_a: assert property (!o_busy |-> !(o_force_pwm_first | o_force_pwm_second)) else $error("idle");
   meas_end_a: assert property ($rose(o_busy) ##0 !sel_wr [*4] |=> !o_busy) else $error("end");
   irq_done_a: assert property ($fell(o_host_interrupt_line_n) |-> $fell(o_busy)) else $error("irq");
   rd_hold_a: assert property (!$past(i_rd) |-> $stable(o_rdata)) else $error("hold");
   unmap_rd_a: assert property (i_rd && i_addr > 8'h04 |=> o_rdata == 8'h00) else $error("unmap");
   high_res_a: assert property (i_rd && i_addr == 8'h02 |=> o_rdata[7:1] == 7'h00) else $error("high");
endmodule // load_meas_props

/* File: tb/buck_load_current_measure_bench.sv */
`timescale 1ns/1ps
module buck_load_current_measure_bench;
   logic       i_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, f0, f1, busy, irq_n;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
   logic [8:0] c0, c1;
   int         n_errors = 0, checked = 0, cyc = 0;
   initial forever #25 i_clk = ~i_clk;
   sense_front_end pm_u (.o_first(c0), .o_second(c1));
   buck_load_current_measure #(.CONV_CYC(4)) dut_u (.i_clk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata,
      .o_rdata, .i_adc_first(c0), .i_adc_second(c1), .o_force_pwm_first(f0), .o_force_pwm_second(f1),
      .o_busy(busy), .o_host_interrupt_line_n(irq_n));
   task chk(input string s, input logic [8:0] e, input logic [8:0] g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s exp %h seen %h", s, e, g);
         n_errors++;
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk) begin i_wr <= w; i_rd <= !w; i_addr <= a; i_wdata <= d; end
      @(posedge i_clk) begin i_wr <= 0; i_rd <= 0; end
      #1;
   endtask
   task t_meas(input logic s, input logic [8:0] e, input logic m);
      bus(1, 8'h04, {7'h0, m});
      bus(1, 8'h00, {7'h0, s});
      chk("pwm", s ? 9'h2 : 9'h1, {7'h0, f1, f0});
      repeat (5) @(posedge i_clk);
      #1 chk("irq", {8'h0, m}, {8'h0, irq_n});
      bus(0, 8'h03, 8'h0); chk("flag", 9'h1, {1'b0, o_rdata});
      bus(0, 8'h01, 8'h0); chk("low", e[7:0], {1'b0, o_rdata});
      bus(0, 8'h02, 8'h0); chk("high", e[8], {1'b0, o_rdata});
      bus(1, 8'h03, 8'h1);
   endtask
   task t_refuse;
      bus(1, 8'h01, 8'hff);
      bus(0, 8'h01, 8'h0); chk("ro", 9'ha5, {1'b0, o_rdata});
      bus(0, 8'h07, 8'h0); chk("unmap", 9'h0, {1'b0, o_rdata});
   endtask
   task t_reset;
      bus(1, 8'h00, 8'h01);
      @(posedge i_clk) i_rstn <= 0;
      repeat (2) @(posedge i_clk);
      #1 chk("rst busy", 9'h0, {8'h0, busy});
      chk("rst irq", 9'h1, {8'h0, irq_n});
      chk("rst rdata", 9'h0, {1'b0, o_rdata});
      @(posedge i_clk) i_rstn <= 1;
      bus(0, 8'h00, 8'h0); chk("select", 9'h0, {1'b0, o_rdata});
      bus(1, 8'h04, 8'h5a);
      bus(0, 8'h04, 8'h0); chk("mask", 9'h5a, {1'b0, o_rdata});
   endtask
   task complete_run;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge i_clk) if (++cyc > 3000) begin
      n_errors++;
      complete_run;
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_rstn <= 1;
      t_meas(1, 9'h0f3, 1);
      t_meas(0, 9'h1a5, 0);
      t_refuse;
      t_reset;
      complete_run;
   end
endmodule // buck_load_current_measure_bench
bind buck_load_current_measure load_meas_props pr_u (.i_clk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
   .o_force_pwm_first, .o_force_pwm_second, .o_busy, .o_host_interrupt_line_n);
